// ### include/fuse_cfg_pkg.sv
// Constants, field layouts and enumerations for the configuration fuse loader
package fuse_cfg_pkg;

  localparam int FUSE_COUNT = 9;
  localparam int ADDR_W = 4;
  localparam int CLK_HZ = 20000000;

  // Fuse offsets
  localparam logic [3:0] OFS_WATCHDOG = 4'h0;
  localparam logic [3:0] OFS_BROWNOUT = 4'h1;
  localparam logic [3:0] OFS_OSC = 4'h2;
  localparam logic [3:0] OFS_RSVD_A = 4'h3;
  localparam logic [3:0] OFS_RSVD_B = 4'h4;
  localparam logic [3:0] OFS_SYS_A = 4'h5;
  localparam logic [3:0] OFS_SYS_B = 4'h6;
  localparam logic [3:0] OFS_CODE_SIZE = 4'h7;
  localparam logic [3:0] OFS_BOOT_SIZE = 4'h8;

  // Implemented-bit masks; other bits are reserved and read as zero
  localparam logic [7:0] MASK_WATCHDOG = 8'hFF;
  localparam logic [7:0] MASK_BROWNOUT = 8'hFF;
  localparam logic [7:0] MASK_OSC = 8'h0F;
  localparam logic [7:0] MASK_SYS_A = 8'hF9;
  localparam logic [7:0] MASK_SYS_B = 8'h1F;
  localparam logic [7:0] MASK_SIZE = 8'hFF;

  // Field positions
  localparam int WIN_LSB = 4;
  localparam int PER_LSB = 0;
  localparam int LVL_LSB = 5;
  localparam int SAMP_BIT = 4;
  localparam int ACT_LSB = 2;
  localparam int SLP_LSB = 0;
  localparam int CLK_LSB = 0;
  localparam int SRC_LSB = 6;
  localparam int POLY_BIT = 5;
  localparam int PROG_BIT = 4;
  localparam int RST_BIT = 3;
  localparam int KEEP_BIT = 0;
  localparam int MV_LSB = 3;
  localparam int SUT_LSB = 0;

  // Register reset values (not factory contents)
  localparam logic [7:0] FUSE_RESET = 8'h00;

  // Shipped system fuse A contents, informative only
  localparam logic [7:0] SYS_A_SHIPPED = 8'hD0;

  // Size unit in bytes
  localparam int SECTION_BLOCK_BYTES = 512;

  // Threshold codes and reserved limit
  localparam logic [2:0] LVL_MAX_CODE = 3'h3;

  // Start-up delay table in ms
  localparam int SUT_MS_0 = 0;
  localparam int SUT_MS_7 = 64;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;

  typedef enum logic [1:0] {
    BOD_OFF,
    BOD_CONTINUOUS,
    BOD_SAMPLED,
    BOD_CONT_HOLD
  } bod_mode_e;

  typedef enum logic [1:0] {
    SCAN_ALL,
    SCAN_BOOT,
    SCAN_BOOT_APP,
    SCAN_NONE
  } scan_region_e;

  typedef enum {
    LD_RESET,
    LD_SAMPLE,
    LD_DELAY,
    LD_RUN
  } load_state_e;

  function automatic logic [31:0] sut_cycles(input logic [2:0] code);
    logic [31:0] ms;
    ms = (code == 3'h0) ? 32'h0000_0000 : (32'h0000_0001 << (code - 3'h1));
    return ms * CYCLES_PER_MS;
  endfunction

endpackage

// ### test/boot_target_model.sv
// Watchdog and brown-out control registers that take the loaded fields
`timescale 1ns/100ps
module boot_target_model (
  // Clock and load level
  input wire logic clock_in,
  input wire logic load_in,
  // Fields offered by the loader
  input wire logic [3:0] window_in,
  input wire logic [3:0] period_in,
  input wire logic [2:0] level_in,
  input wire logic rate_in,
  input wire logic [1:0] active_in,
  input wire logic [1:0] sleep_in,
  // Captured control registers
  output logic [7:0] wd_ctrl_first_out,
  output logic [7:0] bod_ctrl_first_out,
  output logic [7:0] bod_ctrl_second_out
);
  logic load_q = 1'b0;
  // Capture only on the rise, as a reset-time write would
  always_ff @(posedge clock_in) begin
    load_q <= load_in;
    if (load_in && !load_q) begin
      wd_ctrl_first_out <= {window_in, period_in};
      bod_ctrl_first_out <= {3'h0, rate_in, active_in, sleep_in};
      bod_ctrl_second_out <= {5'h00, level_in};
    end
  end
endmodule

// ### test/fuse_config_loader_properties.sv
// Port assertions for the fuse configuration loader
`timescale 1ns/100ps
module fuse_config_loader_properties (
  // Clock, reset and requests
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic cpu_rd_in,
  input wire logic [3:0] cpu_addr_in,
  input wire logic chip_erase_in,
  // Observed outputs
  input wire logic [7:0] cpu_rdata_out,
  input wire logic erase_flash_out,
  input wire logic erase_eeprom_out,
  input wire logic eeprom_keep_on_erase_out,
  input wire logic [3:0] wd_window_out,
  input wire logic [3:0] wd_period_out,
  input wire logic [2:0] brownout_threshold_sel_out,
  input wire logic brownout_threshold_valid_out,
  input wire logic [1:0] bod_active_mode_out,
  input wire logic bod_hold_at_wake_out,
  input wire logic [1:0] bod_sleep_mode_out,
  input wire logic bod_sleep_mode_valid_out,
  input wire logic [1:0] scan_region_sel_out,
  input wire logic scan_enable_out,
  input wire logic config_valid_out,
  input wire logic cpu_run_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////
  a_erase_gate: assert property (
    erase_eeprom_out == (chip_erase_in && !eeprom_keep_on_erase_out) && erase_flash_out == chip_erase_in)
    else $error("erase outputs disagree with keep bit");
  a_level_flag: assert property (brownout_threshold_valid_out == (brownout_threshold_sel_out <= 3'h3))
    else $error("threshold valid flag wrong");
  a_hold_flag: assert property (bod_hold_at_wake_out == (bod_active_mode_out == 2'h3))
    else $error("hold at wake flag wrong");
  a_sleep_flag: assert property (bod_sleep_mode_valid_out == (bod_sleep_mode_out != 2'h3))
    else $error("sleep mode valid flag wrong");
  a_scan_flag: assert property (scan_enable_out == (scan_region_sel_out != 2'h3))
    else $error("scan enable flag wrong");
  a_fields_frozen: assert property (
    config_valid_out && $past(config_valid_out) |-> $stable({wd_window_out, wd_period_out, brownout_threshold_sel_out}))
    else $error("latched fields moved while running");
  a_reset_clear: assert property (
    $rose(rstn_in) |-> {wd_window_out, wd_period_out, brownout_threshold_sel_out, config_valid_out, cpu_run_out} == '0)
    else $error("fields not cleared in reset");
  a_load_time: assert property ($rose(rstn_in) |-> ##[9:15] config_valid_out)
    else $error("configuration not loaded in time");
  a_run_order: assert property (cpu_run_out |-> config_valid_out)
    else $error("run before configuration loaded");
  a_gap_reads: assert property (
    cpu_rd_in && (cpu_addr_in == 4'h3 || cpu_addr_in == 4'h4 || cpu_addr_in > 4'h8) |=> cpu_rdata_out == 8'h00)
    else $error("reserved offset read not zero");
endmodule

bind fuse_config_loader fuse_config_loader_properties fuse_config_loader_properties_i (.clock_in, .rstn_in,
  .cpu_rd_in, .cpu_addr_in, .chip_erase_in, .cpu_rdata_out, .erase_flash_out, .erase_eeprom_out,
  .eeprom_keep_on_erase_out, .wd_window_out, .wd_period_out, .brownout_threshold_sel_out,
  .brownout_threshold_valid_out, .bod_active_mode_out, .bod_hold_at_wake_out, .bod_sleep_mode_out,
  .bod_sleep_mode_valid_out, .scan_region_sel_out, .scan_enable_out, .config_valid_out, .cpu_run_out);

// ### test/tb_top.sv
// Self-checking bench for the fuse configuration loader
`timescale 1ns/100ps
module tb_top;
  import fuse_cfg_pkg::*;
  typedef logic [7:0] fuse_set_t [9];
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic prog_wr_in = 1'b0;
  logic [3:0] prog_addr_in = 4'h0;
  logic [7:0] prog_wdata_in = 8'h00;
  logic cpu_rd_in = 1'b0;
  logic [3:0] cpu_addr_in = 4'h0;
  logic chip_erase_in = 1'b0;
  logic [7:0] cpu_rdata_out, code_region_size_out, boot_region_size_out, wd_a, bod_a, bod_b;
  logic [3:0] wd_window_out, wd_period_out, default_osc_choice_out;
  logic [2:0] brownout_threshold_sel_out, startup_delay_sel_out;
  logic [1:0] bod_active_mode_out, bod_sleep_mode_out, scan_region_sel_out, dual_supply_mode_out;
  logic erase_flash_out, erase_eeprom_out, brownout_threshold_valid_out, brownout_sample_rate_out;
  logic bod_sleep_mode_valid_out, bod_hold_at_wake_out, osc_is_slow_out, osc_choice_valid_out;
  logic scan_enable_out, scan_poly_sel_out, prog_pin_function_out, reset_pin_function_out;
  logic eeprom_keep_on_erase_out, boot_is_whole_flash_out, config_valid_out, cpu_run_out;
  int errors = 0;
  int check_count = 0;
  fuse_set_t s;

  fuse_config_loader fuse_config_loader_i (.*);
  boot_target_model boot_target_model_i (.clock_in(clock_in), .load_in(config_valid_out),
    .window_in(wd_window_out), .period_in(wd_period_out), .level_in(brownout_threshold_sel_out),
    .rate_in(brownout_sample_rate_out), .active_in(bod_active_mode_out), .sleep_in(bod_sleep_mode_out),
    .wd_ctrl_first_out(wd_a), .bod_ctrl_first_out(bod_a), .bod_ctrl_second_out(bod_b));

  always #25 clock_in = ~clock_in;
  ////////////////////////////////////////
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Stored and read-back view: reserved bits and offsets give zero
  function automatic logic [7:0] live(input int a, input logic [7:0] d);
    case (a)
      0, 1, 7, 8: return d;
      2: return d & 8'h0F;
      5: return d & 8'hF9;
      6: return d & 8'h1F;
      default: return 8'h00;
    endcase
  endfunction
  task automatic prog_all(input fuse_set_t v);
    for (int i = 0; i < 10; i++) begin
      @(posedge clock_in);
      prog_wr_in <= 1'b1;
      prog_addr_in <= i[3:0];
      prog_wdata_in <= (i < 9) ? v[i] : 8'h77;
      @(posedge clock_in);
      prog_wr_in <= 1'b0;
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    cpu_rd_in <= 1'b1;
    cpu_addr_in <= a;
    @(posedge clock_in);
    cpu_rd_in <= 1'b0;
    #1 check8(cpu_rdata_out, exp);
  endtask
  task automatic restart(input int lo, input int hi);
    int n = 0;
    @(posedge clock_in);
    rstn_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    rstn_in <= 1'b1;
    while (config_valid_out !== 1'b1 && n < 40) begin
      @(posedge clock_in);
      n++;
    end
    n = 0;
    while (cpu_run_out !== 1'b1 && n < 21000) begin
      @(posedge clock_in);
      n++;
    end
    check8({7'h00, n >= lo && n <= hi}, 8'h01);
    #1;
  endtask
  task automatic check_fields(input fuse_set_t v);
    fuse_set_t m;
    for (int i = 0; i < 9; i++) m[i] = live(i, v[i]);
    check8({wd_window_out, wd_period_out}, m[0]);
    check8({brownout_threshold_sel_out, brownout_sample_rate_out, bod_active_mode_out, bod_sleep_mode_out}, m[1]);
    check8({4'h0, default_osc_choice_out}, m[2]);
    check8({scan_region_sel_out, scan_poly_sel_out, prog_pin_function_out, reset_pin_function_out, 2'h0,
      eeprom_keep_on_erase_out}, m[5]);
    check8({3'h0, dual_supply_mode_out, startup_delay_sel_out}, m[6]);
    check8(code_region_size_out, m[7]);
    check8(boot_region_size_out, m[8]);
    check8({brownout_threshold_valid_out, bod_hold_at_wake_out, bod_sleep_mode_valid_out, scan_enable_out,
      osc_is_slow_out, osc_choice_valid_out, boot_is_whole_flash_out, 1'b0}, {m[1][7:5] <= 3'h3,
      m[1][3:2] == 2'h3, m[1][1:0] != 2'h3, m[5][7:6] != 2'h3, m[2] == 8'h01, m[2] <= 8'h01, m[8] == 8'h00,
      1'b0});
    check8(wd_a, m[0]);
    check8(bod_a, {3'h0, m[1][4:0]});
    check8(bod_b, {5'h00, m[1][7:5]});
  endtask
  task automatic erase_check(input logic [7:0] exp);
    @(posedge clock_in);
    chip_erase_in <= 1'b1;
    @(posedge clock_in);
    #1 check8({6'h00, erase_flash_out, erase_eeprom_out}, exp);
    @(posedge clock_in);
    chip_erase_in <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    s = '{8'hA5, 8'h6E, 8'hF1, 8'h33, 8'h44, 8'hFF, 8'hE8, 8'h12, 8'h00};
    prog_all(s);
    restart(0, 3);
    check_fields(s);
    for (int i = 0; i < 16; i++) rd(i[3:0], live(i, (i < 9) ? s[i] : 8'h00));
    erase_check(8'h02);
    $display("test load and readback done");
    s = '{8'h3C, 8'h91, 8'h00, 8'h00, 8'h00, 8'h40, 8'h11, 8'h34, 8'h05};
    prog_all(s);
    rd(4'h1, 8'h91);
    check8({wd_window_out, wd_period_out}, 8'hA5);
    restart(19990, 20010);
    check_fields(s);
    erase_check(8'h03);
    $display("test reload and delay done");
    for (int i = 0; i < 8; i++) begin
      s = '{8'h00, {i[2:0], i[0], i[1:0], i[1:0]}, i[7:0], 8'h00, 8'h00, {i[1:0], 6'h00}, 8'h00, 8'h01, i[7:0]};
      prog_all(s);
      restart(0, 3);
      check_fields(s);
    end
    $display("test code sweep done");
    print_verdict();
  end
  initial begin
    #4000000;
    errors++;
    $display("watchdog expired");
    print_verdict();
  end
endmodule

// ### verilog/fuse_config_loader.sv
// Fuse bank latch, start-up sequencing and distribution of boot configuration
`timescale 1ns/100ps

module fuse_config_loader
  import fuse_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rstn_in,
  // Nonvolatile fuse array, programmed only from the single-wire port
  input wire logic prog_wr_in,
  input wire logic [3:0] prog_addr_in,
  input wire logic [7:0] prog_wdata_in,
  // Processor read port
  input wire logic cpu_rd_in,
  input wire logic [3:0] cpu_addr_in,
  output logic [7:0] cpu_rdata_out,
  // Chip erase request
  input wire logic chip_erase_in,
  output logic erase_flash_out,
  output logic erase_eeprom_out,
  // Watchdog targets
  output logic [3:0] wd_window_out,
  output logic [3:0] wd_period_out,
  // Brown-out targets
  output logic [2:0] brownout_threshold_sel_out,
  output logic brownout_threshold_valid_out,
  output logic brownout_sample_rate_out,
  output logic [1:0] bod_active_mode_out,
  output logic [1:0] bod_sleep_mode_out,
  output logic bod_sleep_mode_valid_out,
  output logic bod_hold_at_wake_out,
  // Clock targets
  output logic [3:0] default_osc_choice_out,
  output logic osc_is_slow_out,
  output logic osc_choice_valid_out,
  // Scanner, pins and memory
  output logic [1:0] scan_region_sel_out,
  output logic scan_enable_out,
  output logic scan_poly_sel_out,
  output logic prog_pin_function_out,
  output logic reset_pin_function_out,
  output logic eeprom_keep_on_erase_out,
  output logic [1:0] dual_supply_mode_out,
  output logic [2:0] startup_delay_sel_out,
  output logic [7:0] code_region_size_out,
  output logic [7:0] boot_region_size_out,
  output logic boot_is_whole_flash_out,
  // Sequencing
  output logic config_valid_out,
  output logic cpu_run_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_sync1_q;
  logic rst_sync2_q;
  logic rstn;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  assign rstn = rst_sync2_q;

  ////////////////////////////////////////////////////////////////////////////
  // Fuse array
  // Nonvolatile: not cleared by reset, so no reset branch. Written only from
  // the programming port; the processor port has no write path.

  logic [7:0] fuse_mem [FUSE_COUNT];
  logic [7:0] fuse_mask [FUSE_COUNT];

  function automatic logic [7:0] mask_of(input logic [3:0] ofs);
    case (ofs)
      OFS_WATCHDOG: return MASK_WATCHDOG;
      OFS_BROWNOUT: return MASK_BROWNOUT;
      OFS_OSC: return MASK_OSC;
      OFS_SYS_A: return MASK_SYS_A;
      OFS_SYS_B: return MASK_SYS_B;
      OFS_CODE_SIZE: return MASK_SIZE;
      OFS_BOOT_SIZE: return MASK_SIZE;
      default: return 8'h00;
    endcase
  endfunction

  wire prog_hit = prog_wr_in && (prog_addr_in < 4'(FUSE_COUNT));

  // Reserved bits are stored as zero whatever the programmer sends
  always_ff @(posedge clock_in) begin
    if (prog_hit) begin
      fuse_mem[prog_addr_in] <= prog_wdata_in & mask_of(prog_addr_in);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load sequencer

  load_state_e state_q;
  load_state_e state_d;
  logic [3:0] idx_q;
  logic [31:0] delay_q;
  logic [7:0] latch_q [FUSE_COUNT];
  logic delay_done;

  assign delay_done = delay_q == 32'h0000_0000;

  always_comb begin
    case (state_q)
      LD_RESET: state_d = LD_SAMPLE;
      LD_SAMPLE: state_d = (idx_q == 4'(FUSE_COUNT - 1)) ? LD_DELAY : LD_SAMPLE;
      LD_DELAY: state_d = delay_done ? LD_RUN : LD_DELAY;
      LD_RUN: state_d = LD_RUN;
      default: state_d = LD_RESET;
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      state_q <= LD_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // Bytes are walked one per cycle to model a serial array read-out
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      idx_q <= 4'h0;
    end else if (state_q == LD_SAMPLE) begin
      idx_q <= idx_q + 4'h1;
    end
  end

  // Latches load once per reset; later programming waits for the next reset
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < FUSE_COUNT; i++) begin
        latch_q[i] <= FUSE_RESET;
      end
    end else if (state_q == LD_SAMPLE) begin
      latch_q[idx_q] <= fuse_mem[idx_q] & mask_of(idx_q);
    end
  end

  // Start-up delay taken from the freshly latched system fuse B
  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      delay_q <= 32'h0000_0000;
    end else if (state_q == LD_SAMPLE && state_d == LD_DELAY) begin
      delay_q <= sut_cycles(latch_q[OFS_SYS_B][SUT_LSB +: 3]);
    end else if (state_q == LD_DELAY && !delay_done) begin
      delay_q <= delay_q - 32'h0000_0001;
    end
  end

  assign config_valid_out = (state_q == LD_DELAY) || (state_q == LD_RUN);
  assign cpu_run_out = state_q == LD_RUN;

  ////////////////////////////////////////////////////////////////////////////
  // Distribution

  fuse_field_decode u_decode (
    .wd_byte_in(latch_q[OFS_WATCHDOG]),
    .bod_byte_in(latch_q[OFS_BROWNOUT]),
    .osc_byte_in(latch_q[OFS_OSC]),
    .sys_a_byte_in(latch_q[OFS_SYS_A]),
    .sys_b_byte_in(latch_q[OFS_SYS_B]),
    .wd_window_out(wd_window_out),
    .wd_period_out(wd_period_out),
    .brownout_threshold_sel_out(brownout_threshold_sel_out),
    .brownout_threshold_valid_out(brownout_threshold_valid_out),
    .brownout_sample_rate_out(brownout_sample_rate_out),
    .bod_active_mode_out(bod_active_mode_out),
    .bod_sleep_mode_out(bod_sleep_mode_out),
    .bod_sleep_mode_valid_out(bod_sleep_mode_valid_out),
    .bod_hold_at_wake_out(bod_hold_at_wake_out),
    .default_osc_choice_out(default_osc_choice_out),
    .osc_is_slow_out(osc_is_slow_out),
    .osc_choice_valid_out(osc_choice_valid_out),
    .scan_region_sel_out(scan_region_sel_out),
    .scan_enable_out(scan_enable_out),
    .scan_poly_sel_out(scan_poly_sel_out),
    .prog_pin_function_out(prog_pin_function_out),
    .reset_pin_function_out(reset_pin_function_out),
    .eeprom_keep_on_erase_out(eeprom_keep_on_erase_out),
    .dual_supply_mode_out(dual_supply_mode_out),
    .startup_delay_sel_out(startup_delay_sel_out)
  );

  assign code_region_size_out = latch_q[OFS_CODE_SIZE];
  assign boot_region_size_out = latch_q[OFS_BOOT_SIZE];
  assign boot_is_whole_flash_out = latch_q[OFS_BOOT_SIZE] == 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Chip erase

  assign erase_flash_out = chip_erase_in;
  assign erase_eeprom_out = chip_erase_in && !latch_q[OFS_SYS_A][KEEP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Processor read port, returns the array contents

  wire rd_mapped = cpu_addr_in < 4'(FUSE_COUNT);
  wire [7:0] rd_value = rd_mapped ? (fuse_mem[cpu_addr_in] & mask_of(cpu_addr_in)) : 8'h00;

  always_ff @(posedge clock_in or negedge rstn) begin
    if (!rstn) begin
      cpu_rdata_out <= 8'h00;
    end else if (cpu_rd_in) begin
      cpu_rdata_out <= rd_value;
    end
  end

endmodule

// ### verilog/fuse_field_decode.sv
// Decoder of latched fuse bytes into per-target configuration fields
`timescale 1ns/100ps
module fuse_field_decode
  import fuse_cfg_pkg::*;
(
  // Latched fuse bytes
  input wire logic [7:0] wd_byte_in,
  input wire logic [7:0] bod_byte_in,
  input wire logic [7:0] osc_byte_in,
  input wire logic [7:0] sys_a_byte_in,
  input wire logic [7:0] sys_b_byte_in,
  // Watchdog fields
  output logic [3:0] wd_window_out,
  output logic [3:0] wd_period_out,
  // Brown-out fields
  output logic [2:0] brownout_threshold_sel_out,
  output logic brownout_threshold_valid_out,
  output logic brownout_sample_rate_out,
  output logic [1:0] bod_active_mode_out,
  output logic [1:0] bod_sleep_mode_out,
  output logic bod_sleep_mode_valid_out,
  output logic bod_hold_at_wake_out,
  // Clock fields
  output logic [3:0] default_osc_choice_out,
  output logic osc_is_slow_out,
  output logic osc_choice_valid_out,
  // Scanner and pin fields
  output logic [1:0] scan_region_sel_out,
  output logic scan_enable_out,
  output logic scan_poly_sel_out,
  output logic prog_pin_function_out,
  output logic reset_pin_function_out,
  output logic eeprom_keep_on_erase_out,
  output logic [1:0] dual_supply_mode_out,
  output logic [2:0] startup_delay_sel_out
);

  assign wd_window_out = wd_byte_in[WIN_LSB +: 4];
  assign wd_period_out = wd_byte_in[PER_LSB +: 4];

  assign brownout_threshold_sel_out = bod_byte_in[LVL_LSB +: 3];
  assign brownout_threshold_valid_out = bod_byte_in[LVL_LSB +: 3] <= LVL_MAX_CODE;
  assign brownout_sample_rate_out = bod_byte_in[SAMP_BIT];
  assign bod_active_mode_out = bod_byte_in[ACT_LSB +: 2];
  assign bod_hold_at_wake_out = bod_byte_in[ACT_LSB +: 2] == BOD_CONT_HOLD;
  assign bod_sleep_mode_out = bod_byte_in[SLP_LSB +: 2];
  assign bod_sleep_mode_valid_out = bod_byte_in[SLP_LSB +: 2] != BOD_CONT_HOLD;

  assign default_osc_choice_out = osc_byte_in[CLK_LSB +: 4];
  assign osc_is_slow_out = osc_byte_in[CLK_LSB +: 4] == 4'h1;
  assign osc_choice_valid_out = osc_byte_in[CLK_LSB +: 4] <= 4'h1;

  assign scan_region_sel_out = sys_a_byte_in[SRC_LSB +: 2];
  assign scan_enable_out = sys_a_byte_in[SRC_LSB +: 2] != SCAN_NONE;
  assign scan_poly_sel_out = sys_a_byte_in[POLY_BIT];
  assign prog_pin_function_out = sys_a_byte_in[PROG_BIT];
  assign reset_pin_function_out = sys_a_byte_in[RST_BIT];
  assign eeprom_keep_on_erase_out = sys_a_byte_in[KEEP_BIT];
  assign dual_supply_mode_out = sys_b_byte_in[MV_LSB +: 2];
  assign startup_delay_sel_out = sys_b_byte_in[SUT_LSB +: 3];

endmodule
